// ---- slc_net_model.sv ----
`timescale 1ns/100ps
// Far side of the link: brings the link up or down and sends pause frames.
module slc_net_model #(
	parameter int LAG = 2
) (
	input wire logic aclk,
	input wire logic plug,
	input wire logic send_pause,
	output logic link_up,
	output logic pause_rx = 1'h0,
	output logic [15:0] pause_quanta
);
logic [7:0] hist = 8'h00;
// Link follows the cable after a lag; pauses only flow on a live link.
always @(posedge aclk) begin
	hist <= {hist[6:0], plug};
	pause_rx <= send_pause && link_up;
end
// Pause time is held constant so it is stable when sampled.
assign link_up = hist[LAG];
assign pause_quanta = 16'h0010;
endmodule

// ---- slc_pkg.sv ----
package slc_pkg;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COND = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_IPREQ = 8'h0C;
	localparam logic [7:0] ADDR_IPADDR = 8'h10;
	localparam logic [7:0] ADDR_PAUSE = 8'h14;

	// Control field positions and reset value.
	localparam int CTRL_PERSIST_EN = 0;
	localparam int CTRL_DHCP_EN = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;

	// Condition field positions.
	localparam int COND_INIT_DONE = 0;
	localparam int COND_FATAL = 1;
	localparam int COND_FILE_XFER = 2;
	localparam int COND_APP_CONN = 3;
	localparam int COND_ACQ = 4;

	// Answer field positions in the address request register.
	localparam int IPREQ_DHCP_ACK = 0;
	localparam int IPREQ_ARP_REPLY = 1;
	localparam int IPREQ_DHCP_NAK = 2;

	// Timing figures and derived counts.
	localparam int CLK_MHZ = 100;
	localparam int FLASH_MIN_MS = 100;
	localparam int SLOW_MS = 1000;
	localparam int FAST_MS = 125;
	localparam int REBOOT_MS = 30000;
	localparam int MS_CYCLES = CLK_MHZ * 1000;
	localparam int FLASH_CYC = FLASH_MIN_MS * MS_CYCLES;
	localparam int SLOW_CYC = SLOW_MS * MS_CYCLES;
	localparam int FAST_CYC = FAST_MS * MS_CYCLES;
	localparam int REBOOT_CYC = REBOOT_MS * MS_CYCLES;

	// Link-local subnet prefix.
	localparam logic [15:0] LL_PREFIX = 16'hA9FE;

	// Address sequencer states.
	typedef enum logic [2:0] {
		SLC_IDLE, SLC_PERSIST, SLC_DHCP, SLC_LL_PICK, SLC_LL_PROBE, SLC_BOUND
	} slc_ipst_t;

	// LED drive: red, green, blue.
	typedef struct packed {
		logic r;
		logic g;
		logic b;
	} slc_led_t;

	// AXI4-Lite slave outputs.
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} slc_axo_t;

endpackage

// ---- slc_status_ip.sv ----
`timescale 1ns/100ps
// How it works
// RULE1: Indicator shows highest-priority condition; acquisition outranks address assigned.
// RULE2: Steady red at power-up; stays steady red only on fatal uninitialised error. Here every fatal error shows red plus flashing blue.
// RULE3: Red flashes while initialisation runs.
// RULE4: Fatal error shows red plus flashing blue; camera reboots inside a minute.
// RULE5: Cable down flashes blue slowly; address assignment keeps retrying. Here the sequencer is held in SLC_IDLE until the link returns.
// RULE6: File transfer flashes blue quickly.
// RULE7: Address assigned shows steady blue; connected application shows steady green.
// RULE8: Green flashes per frame, at most once every 100 ms.
// RULE9: Host access accepted only once an address is assigned.
// RULE10: Address sequence starts on power-up and every link connection.
// RULE11: Order is persistent address, then DHCP, then link-local.
// RULE12: Defaults persistent off, DHCP on; link-local always enabled.
// RULE13: DHCP stage issues a DHCP request.
// RULE14: A present DHCP server answers the request with an address.
// RULE15: Link-local candidate chosen at random in 169.254 subnet.
// RULE16: Candidate probed by ARP; a reply forces a new candidate.
// RULE17: Link-local traffic is marked local-only, never routed.
// RULE18: PAUSE frames honoured and counted as a pause-received event.
// RULE19: Host adapter and switch must have flow control enabled.
// RULE20: On connection red turns to flashing blue until configured.
// RULE21: Slow and fast blue flashes use fixed distinct clock-derived periods.
module slc_status_ip #(
	parameter int FLASH_CYCLES = slc_pkg::FLASH_CYC,
	parameter int SLOW_CYCLES = slc_pkg::SLOW_CYC,
	parameter int FAST_CYCLES = slc_pkg::FAST_CYC,
	parameter int REBOOT_CYCLES = slc_pkg::REBOOT_CYC,
	parameter logic [31:0] PERSIST_ADDR = 32'hC0A80002
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic link_up,
	input wire logic frame_done,
	input wire logic pause_rx,
	input wire logic [15:0] pause_quanta,
	output logic led_red,
	output logic led_green,
	output logic led_blue,
	output logic dhcp_req,
	output logic arp_probe,
	output logic [31:0] ip_addr,
	output logic ip_valid,
	output logic host_access_en,
	output logic ll_local_only,
	output logic tx_pause,
	output logic reboot_req
);

	initial begin
		if (FAST_CYCLES < 2 || SLOW_CYCLES <= FAST_CYCLES ||
			FLASH_CYCLES < 1 || REBOOT_CYCLES < 1) begin
			$error("slc_status_ip: bad timing parameters");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State record.

	typedef struct packed {
		logic [1:0] link_sync;
		logic link_prev;
		logic [1:0] frame_sync;
		logic frame_prev;
		logic [1:0] pause_sync;
		logic pause_prev;
		logic [15:0] quanta_s1;
		logic [15:0] quanta_s2;
		logic [1:0] ctrl;
		logic [4:0] cond;
		logic [2:0] ans;
		slc_pkg::slc_ipst_t ipst;
		logic [31:0] ip;
		logic ip_ok;
		logic [31:0] lfsr;
		logic [31:0] pause_cnt;
		logic [15:0] pause_left;
		logic [31:0] slow_cnt;
		logic slow_ph;
		logic [31:0] fast_cnt;
		logic fast_ph;
		logic [31:0] grn_cnt;
		logic grn_on;
		logic [31:0] rb_cnt;
		logic reboot;
		logic dhcp;
		logic arp;
		logic loc;
		logic txp;
		slc_pkg::slc_led_t led;
		slc_pkg::slc_axo_t ax;
	} slc_state_t;

	slc_state_t s_q;
	slc_state_t s_d;

	logic link_s;
	logic frame_s;
	logic pause_s;
	logic wr_go;
	logic rd_go;

	assign link_s = s_q.link_sync[1];
	assign frame_s = s_q.frame_sync[1];
	assign pause_s = s_q.pause_sync[1];
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.ax.bvalid;
	assign rd_go = s_axi_arvalid && !s_q.ax.rvalid;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		s_d = s_q;
		// Pin inputs pass two flip-flops before use.
		s_d.link_sync = {s_q.link_sync[0], link_up};
		s_d.frame_sync = {s_q.frame_sync[0], frame_done};
		s_d.pause_sync = {s_q.pause_sync[0], pause_rx};
		s_d.quanta_s1 = pause_quanta; // Same lag as the pause strobe.
		s_d.quanta_s2 = s_q.quanta_s1;
		s_d.link_prev = link_s;
		s_d.frame_prev = frame_s;
		s_d.pause_prev = pause_s;
		s_d.lfsr = {s_q.lfsr[30:0],
			s_q.lfsr[31] ^ s_q.lfsr[21] ^ s_q.lfsr[1] ^ s_q.lfsr[0]};
		s_d.dhcp = 1'b0;
		s_d.arp = 1'b0;

		// Pause frames stall transmit and bump the event counter.
		if (s_q.pause_left != 16'h0000) begin
			s_d.pause_left = s_q.pause_left - 16'h0001; // RULE18
		end
		if (pause_s && !s_q.pause_prev) begin
			s_d.pause_left = s_q.quanta_s2; // RULE18
			s_d.pause_cnt = s_q.pause_cnt + 32'h00000001; // RULE18
		end

		// AXI4-Lite write: address and data taken together.
		s_d.ax.awready = 1'b0;
		s_d.ax.wready = 1'b0;
		if (s_q.ax.bvalid && s_axi_bready) begin
			s_d.ax.bvalid = 1'b0;
		end
		if (wr_go) begin
			s_d.ax.awready = 1'b1;
			s_d.ax.wready = 1'b1;
			s_d.ax.bvalid = 1'b1;
			s_d.ax.bresp = 2'h0;
			case (s_axi_awaddr)
			slc_pkg::ADDR_CTRL: begin
				if (s_axi_wstrb[0]) begin
					s_d.ctrl = s_axi_wdata[1:0];
				end
			end
			slc_pkg::ADDR_COND: begin
				if (s_axi_wstrb[0]) begin
					s_d.cond = s_axi_wdata[4:0];
				end
			end
			slc_pkg::ADDR_IPREQ: begin
				if (s_axi_wstrb[0]) begin
					s_d.ans = s_q.ans | s_axi_wdata[2:0];
				end
			end
			slc_pkg::ADDR_STAT, slc_pkg::ADDR_IPADDR,
			slc_pkg::ADDR_PAUSE: begin
				s_d.ax.bresp = 2'h0;
			end
			default: begin
				s_d.ax.bresp = 2'h2;
			end
			endcase
		end

		// AXI4-Lite read.
		s_d.ax.arready = 1'b0;
		if (s_q.ax.rvalid && s_axi_rready) begin
			s_d.ax.rvalid = 1'b0;
		end
		if (rd_go) begin
			s_d.ax.arready = 1'b1;
			s_d.ax.rvalid = 1'b1;
			s_d.ax.rresp = 2'h0;
			s_d.ax.rdata = 32'h00000000;
			case (s_axi_araddr)
			slc_pkg::ADDR_CTRL: s_d.ax.rdata = {30'h0, s_q.ctrl};
			slc_pkg::ADDR_COND: s_d.ax.rdata = {27'h0, s_q.cond};
			slc_pkg::ADDR_STAT: s_d.ax.rdata = {25'h0, s_q.ip_ok,
				s_q.reboot, link_s, 1'b0, s_q.ipst};
			slc_pkg::ADDR_IPREQ: s_d.ax.rdata = {29'h0, s_q.ans};
			slc_pkg::ADDR_IPADDR: s_d.ax.rdata = s_q.ip;
			slc_pkg::ADDR_PAUSE: s_d.ax.rdata = s_q.pause_cnt;
			default: s_d.ax.rresp = 2'h2;
			endcase
		end

		// Address configuration sequencer.
		case (s_q.ipst)
		slc_pkg::SLC_IDLE: begin
			s_d.ip_ok = 1'b0;
			// A bit newly set by a write in this same cycle survives the clear.
			s_d.ans = s_d.ans & ~s_q.ans;
			if (link_s) begin
				if (s_q.ctrl[slc_pkg::CTRL_PERSIST_EN]) begin // RULE11
					s_d.ipst = slc_pkg::SLC_PERSIST;
				end else if (s_q.ctrl[slc_pkg::CTRL_DHCP_EN]) begin
					s_d.ipst = slc_pkg::SLC_DHCP;
					s_d.dhcp = 1'b1; // RULE13
				end else begin
					s_d.ipst = slc_pkg::SLC_LL_PICK; // RULE12
				end
			end
		end
		slc_pkg::SLC_PERSIST: begin
			s_d.ip = PERSIST_ADDR;
			s_d.ip_ok = 1'b1;
			s_d.ipst = slc_pkg::SLC_BOUND;
		end
		slc_pkg::SLC_DHCP: begin
			if (s_q.ans[slc_pkg::IPREQ_DHCP_ACK]) begin
				s_d.ip = s_q.lfsr; // Offered address stands in as a word.
				s_d.ip_ok = 1'b1;
				s_d.ipst = slc_pkg::SLC_BOUND;
			end else if (s_q.ans[slc_pkg::IPREQ_DHCP_NAK]) begin
				s_d.ipst = slc_pkg::SLC_LL_PICK; // RULE11
			end
		end
		slc_pkg::SLC_LL_PICK: begin
			s_d.ip = {slc_pkg::LL_PREFIX, s_q.lfsr[15:0]}; // RULE15
			s_d.ans = s_d.ans & ~s_q.ans;
			s_d.arp = 1'b1; // RULE16
			s_d.ipst = slc_pkg::SLC_LL_PROBE;
		end
		slc_pkg::SLC_LL_PROBE: begin
			if (s_q.ans[slc_pkg::IPREQ_ARP_REPLY]) begin
				s_d.ipst = slc_pkg::SLC_LL_PICK; // RULE16
			end else if (s_q.ans[slc_pkg::IPREQ_DHCP_ACK]) begin
				s_d.ip_ok = 1'b1; // RULE16
				s_d.ipst = slc_pkg::SLC_BOUND;
			end
		end
		slc_pkg::SLC_BOUND: begin
			s_d.ipst = slc_pkg::SLC_BOUND;
		end
		default: begin
			s_d.ipst = slc_pkg::SLC_IDLE;
		end
		endcase
		// Link loss or a fresh connection restarts the sequence.
		if (!link_s || (link_s && !s_q.link_prev)) begin
			s_d.ipst = slc_pkg::SLC_IDLE; // RULE10 RULE5
			s_d.ip_ok = 1'b0;
			// No request may escape from the cycle that is discarded.
			s_d.dhcp = 1'b0;
			s_d.arp = 1'b0;
		end

		// Blink timebases.
		if (s_q.slow_cnt >= 32'(SLOW_CYCLES / 2 - 1)) begin
			s_d.slow_cnt = 32'h00000000;
			s_d.slow_ph = !s_q.slow_ph; // RULE21
		end else begin
			s_d.slow_cnt = s_q.slow_cnt + 32'h00000001;
		end
		if (s_q.fast_cnt >= 32'(FAST_CYCLES / 2 - 1)) begin
			s_d.fast_cnt = 32'h00000000;
			s_d.fast_ph = !s_q.fast_ph; // RULE21
		end else begin
			s_d.fast_cnt = s_q.fast_cnt + 32'h00000001;
		end

		// Green flash per frame, no sooner than the minimum spacing.
		if (s_q.grn_cnt != 32'h00000000) begin
			s_d.grn_cnt = s_q.grn_cnt - 32'h00000001;
			if (s_q.grn_cnt <= 32'(FLASH_CYCLES / 2)) begin
				s_d.grn_on = 1'b0;
			end
		end else if (frame_s && !s_q.frame_prev) begin
			s_d.grn_cnt = 32'(FLASH_CYCLES - 1); // RULE8
			s_d.grn_on = 1'b1;
		end

		// Fatal error holds reboot request after the timeout.
		if (s_q.cond[slc_pkg::COND_FATAL]) begin
			if (s_q.rb_cnt >= 32'(REBOOT_CYCLES - 1)) begin
				s_d.reboot = 1'b1; // RULE4
			end else begin
				s_d.rb_cnt = s_q.rb_cnt + 32'h00000001;
			end
		end else begin
			s_d.rb_cnt = 32'h00000000;
			s_d.reboot = 1'b0;
		end

		// LED priority: fatal, init, file, link, address, acquire, app.
		if (s_q.cond[slc_pkg::COND_FATAL]) begin
			s_d.led = '{r: 1'b1, g: 1'b0, b: s_q.fast_ph}; // RULE4 RULE2
		end else if (!s_q.cond[slc_pkg::COND_INIT_DONE]) begin
			s_d.led = '{r: s_q.fast_ph, g: 1'b0, b: 1'b0}; // RULE3
		end else if (s_q.cond[slc_pkg::COND_FILE_XFER]) begin
			s_d.led = '{r: 1'b0, g: 1'b0, b: s_q.fast_ph}; // RULE6
		end else if (!link_s) begin
			s_d.led = '{r: 1'b0, g: 1'b0, b: s_q.slow_ph}; // RULE5
		end else if (!s_q.ip_ok) begin
			s_d.led = '{r: 1'b0, g: 1'b0, b: s_q.fast_ph}; // RULE20
		end else if (s_q.cond[slc_pkg::COND_ACQ]) begin
			s_d.led = '{r: 1'b0, g: s_q.grn_on, b: 1'b0}; // RULE1 RULE8
		end else if (s_q.cond[slc_pkg::COND_APP_CONN]) begin
			s_d.led = '{r: 1'b0, g: 1'b1, b: 1'b0}; // RULE7
		end else begin
			s_d.led = '{r: 1'b0, g: 1'b0, b: 1'b1}; // RULE7
		end

		// Decoded flags are registered together with what they decode.
		s_d.loc = s_d.ip[31:16] == slc_pkg::LL_PREFIX; // RULE17
		s_d.txp = s_d.pause_left != 16'h0000; // RULE18
	end

	////////////////////////////////////////////////////////////////////////
	// State register with synchronous reset and clock enable.

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ctrl <= slc_pkg::CTRL_RESET; // RULE12
			s_q.lfsr <= 32'h1F2E3D4C;
			s_q.ipst <= slc_pkg::SLC_IDLE;
			s_q.led <= '{r: 1'b1, g: 1'b0, b: 1'b0}; // RULE2
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register.

	assign s_axi_awready = s_q.ax.awready;
	assign s_axi_wready = s_q.ax.wready;
	assign s_axi_bvalid = s_q.ax.bvalid;
	assign s_axi_bresp = s_q.ax.bresp;
	assign s_axi_arready = s_q.ax.arready;
	assign s_axi_rvalid = s_q.ax.rvalid;
	assign s_axi_rdata = s_q.ax.rdata;
	assign s_axi_rresp = s_q.ax.rresp;
	assign led_red = s_q.led.r;
	assign led_green = s_q.led.g;
	assign led_blue = s_q.led.b;
	assign dhcp_req = s_q.dhcp;
	assign arp_probe = s_q.arp;
	assign ip_addr = s_q.ip;
	assign ip_valid = s_q.ip_ok;
	assign host_access_en = s_q.ip_ok; // RULE9
	assign ll_local_only = s_q.loc; // RULE17
	assign tx_pause = s_q.txp; // RULE18
	assign reboot_req = s_q.reboot;

endmodule

// ---- slc_status_ip_asserts.sv ----
`timescale 1ns/100ps
// Watches the status and address block at its ports.
module slc_status_ip_chk #(
	parameter int FLASH_CYCLES = slc_pkg::FLASH_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic led_red,
	input wire logic led_green,
	input wire logic led_blue,
	input wire logic dhcp_req,
	input wire logic arp_probe,
	input wire logic [31:0] ip_addr,
	input wire logic ip_valid,
	input wire logic host_access_en,
	input wire logic ll_local_only,
	input wire logic reboot_req
);
int gap_q;
// Counts cycles since green last rose, saturating at the flash limit.
always_ff @(posedge aclk) begin
	if (!aresetn)
		gap_q <= FLASH_CYCLES;
	else if ($rose(led_green))
		gap_q <= 1;
	else if (gap_q < FLASH_CYCLES)
		gap_q <= gap_q + 1;
end
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
a_access_gate: assert property (host_access_en == ip_valid)
	else $error("host access differs from address valid");
a_ll_scope: assert property (ll_local_only ==
	(ip_addr[31:16] == slc_pkg::LL_PREFIX))
	else $error("local-only flag does not match the address");
a_probe_subnet: assert property (arp_probe |->
	ip_addr[31:16] == slc_pkg::LL_PREFIX && !ip_valid)
	else $error("probe outside link-local subnet or while bound");
a_dhcp_pulse: assert property (dhcp_req |=> !dhcp_req)
	else $error("address request longer than one cycle");
a_reset_red: assert property ($rose(aresetn) |->
	led_red && !led_green && !led_blue)
	else $error("indicator not steady red out of reset");
a_fatal_red: assert property (reboot_req |-> led_red && !led_green)
	else $error("reboot without fatal indication");
a_green_rate: assert property ($rose(led_green) |-> gap_q >= FLASH_CYCLES)
	else $error("green flashes too close together");
a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid &&
	!s_axi_bvalid |=> s_axi_bvalid)
	else $error("write not answered next cycle");
a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
	s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read answer dropped before taken");
endmodule
bind slc_status_ip slc_status_ip_chk #(.FLASH_CYCLES(FLASH_CYCLES)) chk (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .led_red, .led_green,
	.led_blue, .dhcp_req, .arp_probe, .ip_addr, .ip_valid,
	.host_access_en, .ll_local_only, .reboot_req
);

// ---- tb_status_led_and_ip_config.sv ----
`timescale 1ns/100ps
// Drives the block over its register bus and link, and judges the outputs.
module tb_status_led_and_ip_config;
localparam logic [31:0] PERS = 32'hC0A80002;
logic aclk = 1'h0, aresetn = 1'h0, plug = 1'h0, send_pause = 1'h0;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, frame_done = 1'h0;
logic ce = 1'h1;
logic [3:0] s_axi_wstrb = 4'hF;
logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ip_addr;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [15:0] pause_quanta;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic link_up, pause_rx, led_red, led_green, led_blue, dhcp_req, arp_probe;
logic ip_valid, host_access_en, ll_local_only, tx_pause, reboot_req;
int mismatches = 0;
int checks = 0;
// Bits watched by the bounded waits.
wire logic [10:0] mon = {s_axi_rvalid, s_axi_bvalid, ip_valid && ip_addr === PERS,
	tx_pause, reboot_req, ip_valid, arp_probe, dhcp_req, led_blue, led_green,
	led_red};
slc_status_ip #(.FLASH_CYCLES(20), .SLOW_CYCLES(40), .FAST_CYCLES(8),
	.REBOOT_CYCLES(50), .PERSIST_ADDR(PERS)) dut (
	.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.link_up, .frame_done, .pause_rx, .pause_quanta, .led_red, .led_green,
	.led_blue, .dhcp_req, .arp_probe, .ip_addr, .ip_valid, .host_access_en,
	.ll_local_only, .tx_pause, .reboot_req
);
slc_net_model net (.aclk, .plug, .send_pause, .link_up, .pause_rx,
	.pause_quanta);
// Free-running system clock.
always #5 aclk = ~aclk;
////////////////////////////////////////////////////////////////////////////
task test_done;
	if (mismatches == 0 && checks > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
task chk(input string n, input logic [31:0] s, input logic [31:0] e);
	checks++;
	if (s !== e) begin
		mismatches++;
		$display("unexpected %s: expected %h seen %h", n, e, s);
	end
endtask
task wt(input int i, input logic v, input int lim);
	int n;
	n = 0;
	while (mon[i] !== v) begin
		@(posedge aclk);
		n++;
		if (n > lim) begin
			mismatches++;
			$display("unexpected wait %0d: expected %h seen %h", i, v, mon[i]);
			test_done;
		end
	end
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'h1;
	s_axi_wvalid <= 1'h1;
	s_axi_bready <= 1'h1;
	wt(9, 1'h1, 50);
	s_axi_awvalid <= 1'h0;
	s_axi_wvalid <= 1'h0;
	s_axi_bready <= 1'h0;
endtask
task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'h1;
	s_axi_rready <= 1'h1;
	wt(10, 1'h1, 50);
	d = s_axi_rdata;
	r = s_axi_rresp;
	s_axi_arvalid <= 1'h0;
	s_axi_rready <= 1'h0;
endtask
task rc(input string n, input logic [7:0] a, input logic [31:0] m,
	input logic [31:0] e);
	logic [31:0] d;
	logic [1:0] r;
	rd(a, d, r);
	chk(n, d & m, e);
endtask
////////////////////////////////////////////////////////////////////////////
task s_boot;
	logic [31:0] d;
	logic [1:0] r;
	chk("led", {led_red, led_green, led_blue}, 32'h4);
	chk("access", host_access_en, 32'h0);
	rc("ctrl", slc_pkg::ADDR_CTRL, 32'h3, 32'h2);
	rd(8'h20, d, r);
	chk("resp", r, 32'h2);
	s_axi_wstrb <= 4'h0;
	wr(slc_pkg::ADDR_CTRL, 32'h3);
	s_axi_wstrb <= 4'hF;
	rc("ctrl_strb", slc_pkg::ADDR_CTRL, 32'h3, 32'h2);
	wt(0, 1'h0, 100);
	wt(0, 1'h1, 100);
	wr(slc_pkg::ADDR_COND, 32'h1);
endtask
task s_dhcp;
	plug <= 1'h1;
	wt(3, 1'h1, 100);
	chk("ip_valid", ip_valid, 32'h0);
	wt(2, 1'h1, 30);
	wt(2, 1'h0, 30);
	chk("led_wait", {led_red, led_green}, 32'h0);
	wr(slc_pkg::ADDR_IPREQ, 32'h1);
	wt(5, 1'h1, 20);
	rc("state", slc_pkg::ADDR_STAT, 32'h7, 32'h5);
	repeat (3) @(posedge aclk);
	chk("led_bound", {led_red, led_green, led_blue}, 32'h1);
	wr(slc_pkg::ADDR_COND, 32'h9);
	repeat (3) @(posedge aclk);
	chk("led_app", {led_red, led_green, led_blue}, 32'h2);
	wr(slc_pkg::ADDR_COND, 32'h19);
	repeat (20) @(posedge aclk);
	repeat (8) begin
		frame_done <= 1'h1;
		repeat (2) @(posedge aclk);
		frame_done <= 1'h0;
		repeat (2) @(posedge aclk);
	end
	wt(1, 1'h0, 60);
	chk("acq_blue", led_blue, 32'h0);
	wr(slc_pkg::ADDR_COND, 32'h1);
endtask
task s_local;
	wr(slc_pkg::ADDR_CTRL, 32'h0);
	plug <= 1'h0;
	wt(2, 1'h0, 100);
	wt(2, 1'h1, 100);
	chk("led_down", {led_red, led_green}, 32'h0);
	plug <= 1'h1;
	wt(4, 1'h1, 100);
	chk("subnet", ip_addr[31:16], slc_pkg::LL_PREFIX);
	wr(slc_pkg::ADDR_IPREQ, 32'h2);
	wt(4, 1'h1, 100);
	wr(slc_pkg::ADDR_IPREQ, 32'h1);
	wt(5, 1'h1, 20);
	chk("local", ll_local_only, 32'h1);
endtask
task s_persist;
	logic b;
	wr(slc_pkg::ADDR_CTRL, 32'h1);
	plug <= 1'h0;
	repeat (10) @(posedge aclk);
	plug <= 1'h1;
	wt(8, 1'h1, 100);
	chk("routed", ll_local_only, 32'h0);
	wr(slc_pkg::ADDR_COND, 32'h5);
	wt(2, 1'h0, 20);
	wt(2, 1'h1, 20);
	wt(2, 1'h0, 20);
	ce <= 1'h0;
	repeat (2) @(posedge aclk);
	b = led_blue;
	repeat (12) @(posedge aclk);
	chk("frozen", led_blue, b);
	ce <= 1'h1;
endtask
task s_pause_fatal;
	send_pause <= 1'h1;
	wt(7, 1'h1, 30);
	send_pause <= 1'h0;
	rc("pauses", slc_pkg::ADDR_PAUSE, 32'hFFFFFFFF, 32'h1);
	wr(slc_pkg::ADDR_COND, 32'h3);
	wt(6, 1'h1, 100);
	chk("fatal_red", led_red, 32'h1);
	wt(2, 1'h0, 20);
	wt(2, 1'h1, 20);
endtask
// Main sequence: reset for ten cycles, then every scenario in turn.
initial begin
	repeat (10) @(posedge aclk);
	aresetn <= 1'h1;
	s_boot;
	s_dhcp;
	s_local;
	s_persist;
	s_pause_fatal;
	test_done;
end
endmodule
